// ### rtl/quad_wiper_register_bank.sv
/*
 Register bank of four 8-bit wiper-position registers with tap selects.
 Assumes a neighbouring serial protocol engine in the same clock domain
 delivers identification bytes, address, data and one-cycle strobes.
*/
// How it works
// - Each potentiometer has an 8-bit volatile register that alone picks its tap.
// - The four registers are separate, so writing one never moves another wiper.
// - Code 00h puts the wiper at the tap next to the low terminal.
// - Code FFh puts the wiper at the tap next to the high terminal.
// - Each step up in code moves the wiper one tap toward the high terminal.
// - After reset all four registers hold mid-scale 80h.
// - The serial engine can read and write every register.
// - Addresses 00h to 03h select registers 0 to 3.
// - A write is identification, address, one data byte, then stop.
// - Reads start a pointer at the address, advance per byte, wrap 03h to 00h.
// - Reading goes on while the host acknowledges each byte.
// - Only an identification byte with the type code and matching select pins sets o_id_match; register requests ignore it.
`timescale 1ns/1ps
module quad_wiper_register_bank
   import wiper_pkg::*;
(
   input  wire logic                       i_mclk,
   input  wire logic                       i_rstn,
   input  wire logic [2:0]                 i_address_select_pins,
   input  wire logic [7:0]                 i_id_byte,
   input  wire logic                       i_id_stb,
   input  wire reg_req_t                   i_req,
   input  wire logic                       i_host_ack,
   output logic                            o_id_match,
   output logic                            o_id_read,
   output logic                            o_addr_ok,
   output logic [7:0]                      o_rdata,
   output logic [NUM_WIPERS*WIPER_W-1:0]   o_wiper_codes,
   output logic [NUM_WIPERS*TAPS-1:0]      o_wiper_taps
);
   logic [WIPER_W-1:0]         wiper_code [NUM_WIPERS];
   logic [NUM_WIPERS-1:0]      wr_en;
   logic [ADDR_W-1:0]          ptr_reg;
   logic [ADDR_W-1:0]          ptr_next;
   logic [ADDR_W-1:0]          ptr_step;
   logic [7:0]                 rdata_reg;
   logic [7:0]                 rdata_next;
   id_chk_t                    id_reg;
   id_chk_t                    id_next;
   logic                       addr_ok_reg;
   logic                       addr_ok_next;
   logic [2:0]                 sel_s1;
   logic [2:0]                 sel_s2;
   logic [2:0]                 sel_s3;
   logic [2:0]                 sel_reg;
   logic [2:0]                 sel_next;
   logic [NUM_WIPERS*TAPS-1:0] taps_comb;
   logic [NUM_WIPERS*TAPS-1:0] taps_next;
   logic [NUM_WIPERS*TAPS-1:0] taps_reg;

   // Address byte inside the register map
   function automatic logic addr_in_map(input logic [7:0] a);
      addr_in_map = (a >= ADDR_WIPER_0) && (a <= ADDR_WIPER_LAST);
   endfunction : addr_in_map

   // Register index in the low address bits
   function automatic logic [ADDR_W-1:0] reg_index(input logic [7:0] a);
      reg_index = a[ADDR_W-1:0];
   endfunction : reg_index

   // Write strobe aimed at wiper k
   function automatic logic write_hits(input reg_req_t r, input int k);
      write_hits = r.write_stb && addr_in_map(r.addr)
                && (reg_index(r.addr) == ADDR_W'(k));
   endfunction : write_hits

   // Type code and select pins both match
   function automatic logic id_accepts(input logic [7:0] b, input logic [2:0] s);
      id_accepts = (b[ID_TYPE_MSB:ID_TYPE_LSB] == ID_TYPE_CODE)
                && (b[ID_SEL_MSB:ID_SEL_LSB] == s);
   endfunction : id_accepts

   // Pointer steps by one, last register rolls over to the first
   function automatic logic [ADDR_W-1:0] wrap_next(input logic [ADDR_W-1:0] p);
      wrap_next = (p == ADDR_WIPER_LAST[ADDR_W-1:0]) ? ADDR_WIPER_0[ADDR_W-1:0]
                                                      : p + ADDR_W'(1);
   endfunction : wrap_next

   // Select pins come from outside: three flops
   always_ff @(posedge i_mclk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         sel_s1 <= 3'h0;
         sel_s2 <= 3'h0;
         sel_s3 <= 3'h0;
      end
      else
      begin
         sel_s1 <= i_address_select_pins;
         sel_s2 <= sel_s1;
         sel_s3 <= sel_s2;
      end
   end

   // Pin value counts once second and third flops agree
   always_comb
   begin
      sel_next = sel_reg;
      if (sel_s2 == sel_s3)
      begin
         sel_next = sel_s3;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         sel_reg <= 3'h0;
      end
      else
      begin
         sel_reg <= sel_next;
      end
   end

   // Identification byte check
   always_comb
   begin
      id_next = id_reg;
      if (i_id_stb)
      begin
         id_next.id_valid = id_accepts(i_id_byte, sel_reg);
         id_next.id_read  = i_id_byte[ID_RW_BIT];
      end
   end

   always_ff @(posedge i_mclk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         id_reg <= '0;
      end
      else
      begin
         id_reg <= id_next;
      end
   end

   // Write enables, one per register
   always_comb
   begin
      for (int k = 0; k < NUM_WIPERS; k++)
      begin
         wr_en[k] = write_hits(i_req, k);
      end
   end

   // One register and one tap decoder per potentiometer
   generate
      for (genvar g = 0; g < NUM_WIPERS; g++)
      begin : g_wiper
         logic [WIPER_W-1:0] code_reg;
         logic [WIPER_W-1:0] code_next;

         always_comb
         begin
            code_next = code_reg;
            if (wr_en[g])
            begin
               code_next = i_req.wdata;
            end
         end

         always_ff @(posedge i_mclk or negedge i_rstn)
         begin
            if (!i_rstn)
            begin
               code_reg <= WIPER_RESET;
            end
            else
            begin
               code_reg <= code_next;
            end
         end

         assign wiper_code[g] = code_reg;
         assign o_wiper_codes[g*WIPER_W +: WIPER_W] = code_reg;

         wiper_tap_decoder #(
            .TAP_COUNT (TAPS)
         ) u_dec (
            .i_code (code_reg),
            .o_taps (taps_comb[g*TAPS +: TAPS])
         );
      end
   endgenerate

   // Read pointer; write beats read beats ack
   always_comb
   begin
      ptr_step = wrap_next(ptr_reg);
      ptr_next = ptr_reg;
      if (i_req.write_stb)
      begin
         ptr_next = ptr_reg;
      end
      else if (i_req.read_stb)
      begin
         ptr_next = reg_index(i_req.addr);
      end
      else if (i_host_ack)
      begin
         ptr_next = ptr_step;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         ptr_reg <= '0;
      end
      else
      begin
         ptr_reg <= ptr_next;
      end
   end

   // Byte to shift out follows the pointer
   always_comb
   begin
      rdata_next = rdata_reg;
      if (i_req.write_stb)
      begin
         rdata_next = rdata_reg;
      end
      else if (i_req.read_stb)
      begin
         rdata_next = wiper_code[reg_index(i_req.addr)];
      end
      else if (i_host_ack)
      begin
         rdata_next = wiper_code[ptr_step];
      end
   end

   always_ff @(posedge i_mclk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         rdata_reg <= 8'h00;
      end
      else
      begin
         rdata_reg <= rdata_next;
      end
   end

   // Address flag follows every register request
   always_comb
   begin
      addr_ok_next = addr_ok_reg;
      if (i_req.write_stb || i_req.read_stb)
      begin
         addr_ok_next = addr_in_map(i_req.addr);
      end
   end

   always_ff @(posedge i_mclk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         addr_ok_reg <= 1'b0;
      end
      else
      begin
         addr_ok_reg <= addr_ok_next;
      end
   end

   // Tap selects registered, one cycle behind the code
   always_comb
   begin
      taps_next = taps_comb;
   end

   always_ff @(posedge i_mclk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         taps_reg <= '0;
      end
      else
      begin
         taps_reg <= taps_next;
      end
   end

   // Outputs straight from flops
   assign o_wiper_taps = taps_reg;
   assign o_rdata      = rdata_reg;
   assign o_id_match   = id_reg.id_valid;
   assign o_id_read    = id_reg.id_read;
   assign o_addr_ok    = addr_ok_reg;
endmodule : quad_wiper_register_bank

// ### common/wiper_pkg.sv
/*
 Constants and types shared by the four-wiper register bank and its decoder.
 Assumes a single 200 MHz clock and an asynchronous active-low reset.
*/
package wiper_pkg;
   localparam int        NUM_WIPERS       = 4;
   localparam int        WIPER_W          = 8;
   localparam int        ADDR_W           = 2;
   localparam logic [7:0] WIPER_RESET     = 8'h80;
   localparam logic [7:0] ADDR_WIPER_0    = 8'h00;
   localparam logic [7:0] ADDR_WIPER_LAST = 8'h03;
   localparam logic [3:0] ID_TYPE_CODE    = 4'hA; // Arbitrary value
   localparam int        ID_TYPE_MSB      = 7;
   localparam int        ID_TYPE_LSB      = 4;
   localparam int        ID_SEL_MSB       = 3;
   localparam int        ID_SEL_LSB       = 1;
   localparam int        ID_RW_BIT        = 0;
   localparam int        TAPS             = 256;

   typedef struct packed {
      logic       write_stb;
      logic       read_stb;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic       id_valid;
      logic       id_read;
   } id_chk_t;
endpackage : wiper_pkg

// ### rtl/wiper_tap_decoder.sv
/*
 One-hot tap decoder for a single potentiometer.
 Assumes the wiper code is registered by the caller.
*/
`timescale 1ns/1ps
module wiper_tap_decoder
   import wiper_pkg::*;
#(
   parameter int TAP_COUNT = TAPS
)(
   input  wire logic [WIPER_W-1:0]   i_code,
   output logic      [TAP_COUNT-1:0] o_taps
);
   // Code 00h at low terminal, FFh at high terminal, one tap per step
   always_comb
   begin
      o_taps = '0;
      o_taps[i_code] = 1'b1;
   end
endmodule : wiper_tap_decoder

// ### testbench/wiper_bank_assertions.sv
/* Port assertions for the wiper bank.
   Assumes select pins held steady. */
`timescale 1ns/1ps
module wiper_bank_assertions
   import wiper_pkg::*;
(
   input wire logic          i_mclk,
   input wire logic          i_rstn,
   input wire logic [2:0]    i_address_select_pins,
   input wire logic [7:0]    i_id_byte,
   input wire logic          i_id_stb,
   input wire reg_req_t      i_req,
   input wire logic          i_host_ack,
   input wire logic          o_id_match,
   input wire logic          o_id_read,
   input wire logic          o_addr_ok,
   input wire logic [7:0]    o_rdata,
   input wire logic [31:0]   o_wiper_codes,
   input wire logic [1023:0] o_wiper_taps
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rstn);
   a_write_code: assert property (i_req.write_stb && i_req.addr <= 8'h03 |=>
      o_wiper_codes[8*$past(i_req.addr[1:0]) +: 8] == $past(i_req.wdata)) else $error("write");
   a_addr_flag: assert property (i_req.write_stb || i_req.read_stb |=>
      o_addr_ok == ($past(i_req.addr) <= 8'h03)) else $error("addr flag");
   a_codes_hold: assert property (!(i_req.write_stb && i_req.addr <= 8'h03) |=>
      $stable(o_wiper_codes)) else $error("code moved");
   a_read_data: assert property (i_req.read_stb && !i_req.write_stb |=>
      o_rdata == o_wiper_codes[8*$past(i_req.addr[1:0]) +: 8]) else $error("read");
   a_ptr_next: assert property (i_req.read_stb && !i_req.write_stb ##1
      i_host_ack && !i_req.read_stb && !i_req.write_stb |=>
      o_rdata == o_wiper_codes[8*2'($past(i_req.addr[1:0], 2) + 2'd1) +: 8]) else $error("ptr");
   a_tap_low: assert property ($past(i_rstn) |->
      o_wiper_taps[255:0] == 256'h1 << $past(o_wiper_codes[7:0])) else $error("tap 0");
   a_tap_high: assert property ($past(i_rstn) |->
      o_wiper_taps[1023:768] == 256'h1 << $past(o_wiper_codes[31:24])) else $error("tap 3");
   a_id_check: assert property (i_id_stb |=> o_id_read == $past(i_id_byte[0]) &&
      o_id_match == ($past(i_id_byte[7:4]) == ID_TYPE_CODE &&
      $past(i_id_byte[3:1]) == i_address_select_pins)) else $error("id");
   cover property (i_req.write_stb && i_req.addr > 8'h03);
   cover property (i_host_ack ##1 o_rdata == o_wiper_codes[7:0]);
   cover property (i_id_stb ##1 o_id_match);
endmodule : wiper_bank_assertions
bind quad_wiper_register_bank wiper_bank_assertions wiper_bank_assertions_i (.*);

// ### testbench/host_engine_model.sv
/* Host-side engine model presenting requests.
   Assumes calls made from the bench only. */
`timescale 1ns/1ps
module host_engine_model
   import wiper_pkg::*;
(
   input  wire logic  i_mclk,
   output reg_req_t   o_req,
   output logic       o_ack,
   output logic       o_id_stb,
   output logic [7:0] o_id_byte
);
   initial {o_req, o_ack, o_id_stb, o_id_byte} = '0;
   // Kind bits: write, read, ack, id
   task automatic send(input logic [3:0] kind, input logic [7:0] a, d);
      @(negedge i_mclk);
      o_req     = '{kind[0], kind[1], a, d};
      o_ack     = kind[2];
      o_id_stb  = kind[3];
      o_id_byte = d;
   endtask : send
endmodule : host_engine_model

// ### testbench/test_quad_wiper_register_bank.sv
/* Self-checking bench with a reference array.
   Assumes the host model drives every request. */
`timescale 1ns/1ps
module test_quad_wiper_register_bank;
   import wiper_pkg::*;
   logic          i_mclk = 0, i_rstn = 0, i_host_ack, i_id_stb, o_id_match, o_id_read, o_addr_ok;
   logic [2:0]    i_address_select_pins;
   logic [7:0]    i_id_byte, o_rdata;
   reg_req_t      i_req;
   logic [31:0]   o_wiper_codes;
   logic [1023:0] o_wiper_taps;
   int            num_errors = 0, tests_run = 0, model[4], a, d;
   initial forever #2.5 i_mclk = ~i_mclk;
   host_engine_model host_engine_model_i (.i_mclk, .o_req(i_req), .o_ack(i_host_ack),
      .o_id_stb(i_id_stb), .o_id_byte(i_id_byte));
   quad_wiper_register_bank quad_wiper_register_bank_i (
      .i_mclk, .i_rstn, .i_address_select_pins, .i_id_byte, .i_id_stb, .i_req,
      .i_host_ack, .o_id_match, .o_id_read, .o_addr_ok, .o_rdata, .o_wiper_codes,
      .o_wiper_taps);
   task automatic chk(input string n, input logic [7:0] e, g);
      tests_run++;
      if (g !== e)
      begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic idle2;
      host_engine_model_i.send(0, 8'h00, 8'h00);
      host_engine_model_i.send(0, 8'h00, 8'h00);
      for (int i = 0; i < 4; i++)
      begin
         chk("code", model[i][7:0], o_wiper_codes[8*i +: 8]);
         chk("tap", 8'h01, {7'h00, o_wiper_taps[256*i +: 256] === 256'h1 << model[i]});
      end
   endtask : idle2
   task automatic do_reset(input int n);
      model = '{default: 8'h80};
      i_rstn = 0;
      repeat (n) @(negedge i_mclk);
      i_rstn = 1;
      idle2;
   endtask : do_reset
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : give_verdict
   initial
   begin
      a = $urandom(32'h80A5FE0D);
      i_address_select_pins = 3'($urandom);
      do_reset(8);
      for (int i = 0; i < 40; i++)
      begin
         a = i < 8 ? i % 4 : $urandom % 6;
         d = i < 8 ? (i < 4 ? 0 : 255) : $urandom % 256;
         host_engine_model_i.send(1, a[7:0], d[7:0]);
         if (a < 4)
            model[a] = d;
         @(posedge i_mclk) #1;
         for (int k = 0; k < 4; k++)
            chk("code", model[k][7:0], o_wiper_codes[8*k +: 8]);
         chk("addr_ok", {7'h00, a < 4}, {7'h00, o_addr_ok});
         if (i == 3 || i == 7)
            idle2;
      end
      idle2;
      for (int i = 0; i < 4; i++)
      begin
         host_engine_model_i.send(2, i[7:0], 8'h00);
         host_engine_model_i.send(4, 8'h00, 8'h00);
         chk("rdata", model[i][7:0], o_rdata);
         host_engine_model_i.send(4, 8'h00, 8'h00);
         chk("rdata", model[(i + 1) % 4][7:0], o_rdata);
      end
      host_engine_model_i.send(0, 8'h00, 8'h00);
      do_reset(2);
      idle2;
      for (int i = 0; i < 16; i++)
      begin
         d = {i % 2 ? ID_TYPE_CODE : 4'($urandom),
              i % 4 < 2 ? i_address_select_pins : 3'($urandom), 1'($urandom)};
         host_engine_model_i.send(8, 8'h00, d[7:0]);
         host_engine_model_i.send(0, 8'h00, 8'h00);
         chk("id", {6'h00, d[7:4] == ID_TYPE_CODE && d[3:1] == i_address_select_pins, d[0]},
             {6'h00, o_id_match, o_id_read});
      end
      give_verdict;
   end
   initial
   begin
      #20000;
      num_errors++;
      give_verdict;
   end
endmodule : test_quad_wiper_register_bank
